// ---- hdl/fst_delay_rom.sv ----
// Delay table: configuration key in, registered delays out.
// Assumes the key is steady for a cycle before its result is used.
`timescale 1ns/1ps
module fst_delay_rom (
   input  wire logic i_sys_clk,
   input  wire logic i_resetn,
   fst_lut_if.rom    lut
);
   import fst_pkg::*;
   logic                 div8;
   logic                 grpb;
   logic [DEC_W-1:0]     da;
   logic [DEC_W-1:0]     db;
   logic [DEC_W-1:0]     ai;
   logic                 next_valid;
   logic [CNT_W-1:0]     next_first;
   logic [CNT_W-1:0]     next_a;
   logic [CNT_W-1:0]     next_b;

   // Key fields
   assign {div8, grpb, da, db} = lut.key;
   assign ai = da - 3'h1;

   // Lookup by group usage
   always_comb begin
      next_valid = 1'b0;
      next_first = '0;
      next_a     = '0;
      next_b     = '0;
      if (!grpb && da < NUM_DEC) begin
         next_valid = 1'b1;
         next_first = CNT_W'(SOLO_FIRST[div8][da]);
         next_a     = CNT_W'(SOLO_SETTLE[div8][da]);
      end else if (grpb && da == 3'h0 && db < NUM_DEC) begin
         next_valid = 1'b1;
         next_first = CNT_W'(MIX_FIRST[div8]);
         next_a     = CNT_W'(MIX_SET_A[div8]);
         next_b     = CNT_W'(MIX_SET_B[div8][db]);
      end else if (grpb && db == 3'h0 && da != 3'h0 && da < NUM_DEC) begin
         next_valid = 1'b1;
         next_first = CNT_W'(SLOWA_FIRST[div8][ai]);
         next_a     = CNT_W'(SLOWA_SET_A[div8][ai]);
         next_b     = CNT_W'(SLOWA_SET_B[div8][ai]);
      end
   end

   // Registered read data
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         lut.valid <= 1'b0;
         lut.first <= '0;
         lut.set_a <= '0;
         lut.set_b <= '0;
      end else begin
         lut.valid <= next_valid;
         lut.first <= next_first;
         lut.set_a <= next_a;
         lut.set_b <= next_b;
      end
   end
endmodule : fst_delay_rom

// ---- hdl/fst_lut_if.sv ----
// Carrier between the timer and its delay table.
// Assumes both ends on the same clock.
`timescale 1ns/1ps
interface fst_lut_if;
   import fst_pkg::*;
   logic [KEY_W-1:0] key;
   logic             valid;
   logic [CNT_W-1:0] first;
   logic [CNT_W-1:0] set_a;
   logic [CNT_W-1:0] set_b;
   modport rom  (input key, output valid, first, set_a, set_b);
   modport user (output key, input valid, first, set_a, set_b);
endinterface : fst_lut_if

// ---- hdl/fst_pkg.sv ----
// Constants for the filter resync settling timer.
// Assumes one 100 MHz clock standing in for the master clock.
package fst_pkg;
   // APB map
   localparam int          ADDR_W       = 8;
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_STATUS  = 8'h04;
   localparam logic [7:0]  ADDR_ELAPSED = 8'h08;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   // Control fields
   localparam int CTRL_DIV8_BIT = 0;
   localparam int CTRL_GRPB_BIT = 1;
   localparam int CTRL_DECA_LSB = 2;
   localparam int CTRL_DECB_LSB = 5;
   localparam int DEC_W         = 3;
   // Status fields
   localparam int ST_BUSY    = 0;
   localparam int ST_READY   = 1;
   localparam int ST_SET_A   = 2;
   localparam int ST_SET_B   = 3;
   localparam int ST_CFG_ERR = 4;
   // Rates: decimation code 0..5 is 32..1024
   localparam int NUM_DEC       = 6;
   localparam int DEC_BASE_LOG2 = 5;
   localparam int DIV4_LOG2     = 2;
   localparam int CNT_W         = 20;
   localparam int PER_W         = 14;
   localparam int KEY_W         = 8;
   // Delays in master clock periods; first index 0 is divide-by-4, 1 divide-by-8
   localparam int unsigned SOLO_FIRST [2][6] = '{'{336, 620, 1187, 2325, 4601, 9153},
      '{656, 1225, 2359, 4635, 9187, 18291}};
   localparam int unsigned SOLO_SETTLE [2][6] = '{'{8400, 16748, 33443, 66837, 133625, 267201},
      '{16784, 33481, 66871, 133659, 267235, 534387}};
   localparam int unsigned MIX_FIRST [2] = '{758, 820};
   localparam int unsigned MIX_SET_A [2] = '{8822, 16948};
   localparam int unsigned MIX_SET_B [2][6] = '{'{8822, 17014, 33526, 66934, 133622, 267253},
      '{16948, 33588, 66868, 133684, 267316, 534580}};
   localparam int unsigned SLOWA_FIRST [2][5] = '{'{759, 760, 762, 782, 806},
      '{822, 824, 844, 836, 852}};
   localparam int unsigned SLOWA_SET_A [2][5] = '{'{17015, 33528, 66938, 133646, 267302},
      '{33590, 66872, 133708, 267332, 534612}};
   localparam int unsigned SLOWA_SET_B [2][5] = '{'{8823, 8824, 8826, 8846, 8870},
      '{16950, 16952, 16972, 16964, 16980}};
   // Sequencer states
   typedef enum logic [1:0] {
      FST_IDLE = 2'b00,
      FST_WAIT = 2'b01,
      FST_RUN  = 2'b10
   } fst_state_t;
endpackage : fst_pkg

// ---- hdl/fst_resync_timer.sv ----
// Resync settling timer: filter restart, first and periodic data-ready,
// settled flags per rate group, APB control and status.
// Assumes i_resync is synchronous to i_sys_clk and held steady around edges.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module fst_resync_timer #(
   parameter int unsigned P_SIM_SHIFT = 0
) (
   input  wire logic                      i_sys_clk,
   input  wire logic                      i_resetn,
   input  wire logic                      i_resync,
   input  wire logic                      i_psel,
   input  wire logic                      i_penable,
   input  wire logic                      i_pwrite,
   input  wire logic [fst_pkg::ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]               i_pwdata,
   output logic      [31:0]               o_prdata,
   output logic                           o_pready,
   output logic                           o_pslverr,
   output logic                           o_filter_restart,
   output logic                           o_data_ready_strobe,
   output logic                           o_settled_a,
   output logic                           o_settled_b
);
   import fst_pkg::*;

   // Shift shortens the latched table delays for simulation; the latched strobe period is not shortened
   if (P_SIM_SHIFT > 8) begin : g_bad_shift
      $error("P_SIM_SHIFT above 8 is not served");
   end

   // Period counter must hold the slowest strobe spacing
   if (DIV4_LOG2 + DEC_BASE_LOG2 + NUM_DEC >= PER_W) begin : g_bad_period
      $error("PER_W too narrow for the slowest output period");
   end

   fst_lut_if lut ();

   logic [31:0]      ctrl;
   logic             resync_q;
   logic             rise;
   fst_state_t       state;
   logic [CNT_W-1:0] cnt;
   logic [PER_W-1:0] pcnt;
   logic [PER_W-1:0] lat_period;
   logic [CNT_W-1:0] lat_first;
   logic [CNT_W-1:0] lat_a;
   logic [CNT_W-1:0] lat_b;
   logic             lat_grpb;
   logic             lat_div8;
   logic [DEC_W-1:0] lat_deca;
   logic [DEC_W-1:0] lat_decb;
   logic             ready_seen;
   logic             cfg_err;
   logic             busy;
   logic             first_hit;
   logic             per_hit;
   logic             access;
   logic             finish;
   logic [31:0]      next_rdata;
   logic             next_err;

   // Scale a delay down, never below one cycle
   function automatic logic [CNT_W-1:0] shrink(input logic [CNT_W-1:0] v);
      logic [CNT_W-1:0] s;
      s = v >> P_SIM_SHIFT;
      return (s == '0) ? CNT_W'(1) : s;
   endfunction : shrink

   // Delay table, keyed by live configuration
   assign lut.key = {ctrl[CTRL_DIV8_BIT], ctrl[CTRL_GRPB_BIT],
                     ctrl[CTRL_DECA_LSB +: DEC_W], ctrl[CTRL_DECB_LSB +: DEC_W]};

   fst_delay_rom u_rom (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .lut       (lut)
   );

   // Resync edge detect
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         resync_q <= 1'b0;
      end else begin
         resync_q <= i_resync;
      end
   end

   assign rise = i_resync & ~resync_q;

   // Filter restart pulse
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_filter_restart <= 1'b0;
      end else begin
         o_filter_restart <= rise;
      end
   end

   // Latch the delays for this resync
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         lat_first  <= '0;
         lat_a      <= '0;
         lat_b      <= '0;
         lat_grpb   <= 1'b0;
         lat_div8   <= 1'b0;
         lat_deca   <= '0;
         lat_decb   <= '0;
         lat_period <= '0;
      end else if (rise) begin
         lat_first  <= shrink(lut.first);
         lat_a      <= shrink(lut.set_a);
         lat_b      <= shrink(lut.set_b);
         lat_grpb   <= ctrl[CTRL_GRPB_BIT];
         lat_div8   <= ctrl[CTRL_DIV8_BIT];
         lat_deca   <= ctrl[CTRL_DECA_LSB +: DEC_W];
         lat_decb   <= ctrl[CTRL_DECB_LSB +: DEC_W];
         lat_period <= PER_W'(1) << (DIV4_LOG2 + DEC_BASE_LOG2 +
                       int'(ctrl[CTRL_DIV8_BIT]) + int'(ctrl[CTRL_DECA_LSB +: DEC_W]));
      end
   end

   // Event terms
   assign first_hit = (state == FST_WAIT) && (cnt == lat_first - CNT_W'(1));
   assign per_hit   = (state == FST_RUN) && (pcnt == lat_period - PER_W'(1));
   assign busy      = (state != FST_IDLE) && !(o_settled_a && (o_settled_b || !lat_grpb));

   // Sequencer
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= FST_IDLE;
      end else if (rise) begin
         state <= lut.valid ? FST_WAIT : FST_IDLE;
      end else begin
         case (state)
            FST_IDLE: state <= FST_IDLE;
            FST_WAIT: state <= first_hit ? FST_RUN : FST_WAIT;
            FST_RUN:  state <= FST_RUN;
            default:  state <= FST_IDLE;
         endcase
      end
   end

   // Elapsed periods since the first edge after resync
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt <= '0;
      end else if (rise) begin
         cnt <= '0;
      end else if (busy) begin
         cnt <= cnt + CNT_W'(1);
      end
   end

   // Output period counter after first data
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pcnt <= '0;
      end else if (state != FST_RUN || per_hit) begin
         pcnt <= '0;
      end else begin
         pcnt <= pcnt + PER_W'(1);
      end
   end

   // Data-ready strobe, common to every channel
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_data_ready_strobe <= 1'b0;
      end else begin
         o_data_ready_strobe <= !rise && (first_hit || per_hit);
      end
   end

   // Settled flags per group
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_settled_a <= 1'b0;
         o_settled_b <= 1'b0;
      end else if (rise) begin
         o_settled_a <= 1'b0;
         o_settled_b <= 1'b0;
      end else if (state != FST_IDLE) begin
         if (cnt == lat_a - CNT_W'(1)) begin
            o_settled_a <= 1'b1;
         end
         if (lat_grpb && cnt == lat_b - CNT_W'(1)) begin
            o_settled_b <= 1'b1;
         end
      end
   end

   // Status history
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ready_seen <= 1'b0;
         cfg_err    <= 1'b0;
      end else if (rise) begin
         ready_seen <= 1'b0;
         cfg_err    <= ~lut.valid;
      end else if (o_data_ready_strobe) begin
         ready_seen <= 1'b1;
      end
   end

   // APB phases: answer one cycle into access
   assign access = i_psel & i_penable & ~o_pready;
   assign finish = i_psel & i_penable & o_pready;

   // Read mux and unmapped decode
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      case (i_paddr)
         ADDR_CTRL: next_rdata = ctrl;
         ADDR_STATUS: begin
            next_rdata[ST_BUSY]    = busy;
            next_rdata[ST_READY]   = ready_seen;
            next_rdata[ST_SET_A]   = o_settled_a;
            next_rdata[ST_SET_B]   = o_settled_b;
            next_rdata[ST_CFG_ERR] = cfg_err;
         end
         ADDR_ELAPSED: next_rdata = 32'(cnt);
         default: next_err = 1'b1;
      endcase
   end

   // APB answer
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else if (access) begin
         o_pready  <= 1'b1;
         o_prdata  <= i_pwrite ? 32'h0000_0000 : next_rdata;
         o_pslverr <= next_err;
      end else begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end
   end

   // Control register, written at the completing edge
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl <= CTRL_RESET;
      end else if (finish && i_pwrite && i_paddr == ADDR_CTRL) begin
         ctrl <= {24'h00_0000, i_pwdata[7:0]};
      end
   end

   // Checks
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_resetn);

   logic             first_pulse;
   logic [PER_W-1:0] gap_cnt;
   assign first_pulse = o_data_ready_strobe && !ready_seen;

   // Cycles since the last strobe while results repeat
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         gap_cnt <= '0;
      end else if (state != FST_RUN || o_data_ready_strobe) begin
         gap_cnt <= '0;
      end else begin
         gap_cnt <= gap_cnt + PER_W'(1);
      end
   end

   sequence s_restart;
      rise && lut.valid ##1 o_filter_restart && state == FST_WAIT && cnt == '0;
   endsequence

   sequence s_first;
      first_pulse && cnt == lat_first;
   endsequence

   chk_restart_edge: assert property (rise && lut.valid |-> s_restart)
      else $error("resync did not restart the filters");

   chk_first_delay: assert property (first_pulse |-> s_first)
      else $error("first data-ready at wrong count");

   chk_group_b_idle: assert property ((state != FST_IDLE) && !lat_grpb |-> !o_settled_b)
      else $error("unused group B reported settled");

   chk_settle_a_time: assert property ($rose(o_settled_a) |-> cnt == lat_a && state != FST_IDLE)
      else $error("group A settled at wrong count");

   chk_mixed_rates: assert property (first_pulse && lat_grpb && !lat_div8
      && lat_deca == 3'h0 && lat_decb == 3'h1 |-> cnt == shrink(CNT_W'(MIX_FIRST[0])))
      else $error("mixed rate first data-ready wrong");

   chk_mixed_settle_b: assert property ($rose(o_settled_b) && !lat_div8 && lat_deca == 3'h0
      && lat_decb == 3'h1 |-> cnt == shrink(CNT_W'(MIX_SET_B[0][1])))
      else $error("group B settling wrong");

   chk_div4_dec32: assert property (first_pulse && !lat_grpb && !lat_div8 && lat_deca == 3'h0
      |-> cnt == shrink(CNT_W'(SOLO_FIRST[0][0])))
      else $error("div4 decimate 32 first data-ready wrong");

   chk_div4_dec1024: assert property ($rose(o_settled_a) && !lat_grpb && !lat_div8
      && lat_deca == 3'h5 |-> cnt == shrink(CNT_W'(SOLO_SETTLE[0][5])))
      else $error("div4 decimate 1024 settling wrong");

   chk_div8_dec32: assert property (first_pulse && !lat_grpb && lat_div8 && lat_deca == 3'h0
      |-> cnt == shrink(CNT_W'(SOLO_FIRST[1][0])))
      else $error("div8 decimate 32 first data-ready wrong");

   chk_strobe_repeat: assert property (state == FST_RUN && !o_settled_a |-> gap_cnt < lat_period)
      else $error("unsettled results not strobed out");

   chk_settle_b_time: assert property ($rose(o_settled_b) |-> lat_grpb && cnt == lat_b)
      else $error("group B settled at wrong count");

   chk_restart_pulse: assert property (o_filter_restart |=> !o_filter_restart)
      else $error("filter restart longer than one cycle");

   chk_settled_hold: assert property (o_settled_a && !rise |=> o_settled_a)
      else $error("group A settled flag dropped without resync");

   chk_strobe_single: assert property (o_data_ready_strobe |=> !o_data_ready_strobe)
      else $error("data-ready strobe longer than one cycle");

   chk_apb_answer: assert property (access |=> o_pready && !access)
      else $error("bus answer not given after one wait cycle");
endmodule : fst_resync_timer

// ---- sim/fst_host_model.sv ----
// Host partner model: raises the resync input on request, holds it, then drops it.
// Assumes requests come as one-cycle pulses synchronous to the system clock.
`timescale 1ns/1ps
module fst_host_model (
   input  wire logic i_sys_clk,
   input  wire logic i_resetn,
   input  wire logic i_go,
   output logic      o_resync
);
   logic [2:0] hold_cnt;

   // Resync high for four cycles per request; low before each rise
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         hold_cnt <= 3'h0;
      end else if (i_go) begin
         hold_cnt <= 3'h4;
      end else if (hold_cnt != 3'h0) begin
         hold_cnt <= hold_cnt - 3'h1;
      end
   end

   assign o_resync = (hold_cnt != 3'h0);
endmodule : fst_host_model

// ---- sim/tb_top.sv ----
// Testbench for the resync settling timer: APB master, host model, delay checks.
// Assumes the design table delays are shortened by a shift of four.
`timescale 1ns/1ps
module tb_top;
   import fst_pkg::*;
   localparam int SIM_SHIFT = 4;
   logic        i_sys_clk, i_resetn, go, resync, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, restart, strobe, set_a, set_b;
   int          fail_count, checks_done;

   fst_resync_timer #(.P_SIM_SHIFT(SIM_SHIFT)) uut (
      .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_resync(resync), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .o_filter_restart(restart), .o_data_ready_strobe(strobe),
      .o_settled_a(set_a), .o_settled_b(set_b));

   fst_host_model host (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_go(go),
      .o_resync(resync));

   // Clock at 100 MHz
   initial i_sys_clk = 1'b0;
   always #5 i_sys_clk = ~i_sys_clk;

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask : chk

   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int i;
      @(posedge i_sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_sys_clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge i_sys_clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         fail_count++;
         finish_test();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Ask the host for a resync and wait for the filter restart pulse
   task automatic pulse_resync();
      int i;
      @(posedge i_sys_clk);
      go <= 1'b1;
      @(posedge i_sys_clk);
      go <= 1'b0;
      for (i = 0; i < 10; i++) begin
         @(posedge i_sys_clk);
         #1;
         if (restart === 1'b1) break;
      end
      chk("restart", 32'h1, {31'h0, i < 10});
   endtask : pulse_resync

   function automatic int sh(input int v);
      return ((v >> SIM_SHIFT) < 1) ? 1 : (v >> SIM_SHIFT);
   endfunction : sh

   task automatic test_reset();
      logic [31:0] q;
      logic        e;
      apb(1'b0, ADDR_CTRL, 32'h0, q, e);
      chk("ctrl_reset", CTRL_RESET, q);
      apb(1'b0, ADDR_STATUS, 32'h0, q, e);
      chk("status_reset", 32'h0, q);
      apb(1'b1, 8'h0C, 32'hFF, q, e);
      chk("unmapped_wr_err", 32'h1, {31'h0, e});
      apb(1'b0, 8'h0C, 32'h0, q, e);
      chk("unmapped_rd_err", 32'h1, {31'h0, e});
      chk("unmapped_rd_data", 32'h0, q);
      $display("reset test done");
   endtask : test_reset

   // Configure, resync, then time first strobe and settled levels
   task automatic run_case(input logic [31:0] ctrl, input int f, input int sa,
                           input int sb, input bit twice);
      int          n, tf, ta, tb, ns, per, lim;
      logic [31:0] q;
      logic        e;
      apb(1'b1, ADDR_CTRL, ctrl, q, e);
      repeat (2) @(posedge i_sys_clk);
      if (twice) begin
         pulse_resync();
         repeat (600) @(posedge i_sys_clk);
      end
      pulse_resync();
      tf = -1;
      ta = -1;
      tb = -1;
      ns = 0;
      per = (ctrl[CTRL_DIV8_BIT] ? 8 : 4) * (32 << ctrl[4:2]);
      lim = ((sa > sb) ? sa : sb) + 600;
      for (n = 1; n <= lim; n++) begin
         @(posedge i_sys_clk);
         #1;
         if (set_a === 1'b1 && ta < 0) ta = n;
         if (set_b === 1'b1 && tb < 0) tb = n;
         if (strobe === 1'b1 && tf < 0) tf = n;
         if (strobe === 1'b1 && ta < 0) ns++;
      end
      chk("first_strobe", f, tf);
      chk("settled_a", sa, ta);
      chk("settled_b", sb, tb);
      if (f > 0) begin
         chk("early_strobes", (sa - 1 - f) / per + 1, ns);
      end
      apb(1'b0, ADDR_STATUS, 32'h0, q, e);
      chk("cfg_err", {31'h0, f < 0}, {31'h0, q[ST_CFG_ERR]});
      chk("status_set_a", {31'h0, sa > 0}, {31'h0, q[ST_SET_A]});
      chk("status_set_b", {31'h0, sb > 0}, {31'h0, q[ST_SET_B]});
      chk("status_ready", {31'h0, f > 0}, {31'h0, q[ST_READY]});
      chk("status_busy", 32'h0, {31'h0, q[ST_BUSY]});
      apb(1'b0, ADDR_ELAPSED, 32'h0, q, e);
      chk("elapsed", (sa > sb) ? sa : ((sb > 0) ? sb : 0), q);
      $display("case ctrl %h done", ctrl);
   endtask : run_case

   // Main sequence
   initial begin
      fail_count = 0;
      checks_done = 0;
      i_resetn = 1'b0;
      go = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (16) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      test_reset();
      run_case(32'h00, sh(336), sh(8400), -1, 1'b0);
      run_case(32'h14, sh(9153), sh(267201), -1, 1'b0);
      run_case(32'h01, sh(656), sh(16784), -1, 1'b0);
      run_case(32'h22, sh(758), sh(8822), sh(17014), 1'b0);
      run_case(32'h06, sh(759), sh(17015), sh(8823), 1'b0);
      run_case(32'h23, sh(820), sh(16948), sh(33588), 1'b0);
      run_case(32'h26, -1, -1, -1, 1'b0);
      run_case(32'h00, sh(336), sh(8400), -1, 1'b1);
      finish_test();
   end
endmodule : tb_top
